// file: rtl/hbsd_pkg.sv
// Package for the host bus strobe decode block
package hbsd_pkg;
   localparam int HBSD_ADDR_W = 11;
   localparam int HBSD_DATA_W = 8;
   localparam int HBSD_SYNC_STAGES = 2;
   localparam logic HBSD_MODE_SYNC = 1'b1;
   localparam logic HBSD_MODE_ASYNC = 1'b0;
   localparam logic [HBSD_ADDR_W-1:0] HBSD_ADDR_RST = 11'h000;
   localparam logic [HBSD_DATA_W-1:0] HBSD_DATA_RST = 8'h00;

   typedef enum logic [1:0] {
      HBSD_ACC_NONE,
      HBSD_ACC_READ,
      HBSD_ACC_WRITE
   } hbsd_acc_e;

   // Raw host pins after synchronisation
   typedef struct packed {
      logic port_select_n;
      logic bus_protocol_select;
      logic shared_strobe_n;
      logic shared_dir;
      logic dev_reset_n;
      logic host_port_clock;
      logic [HBSD_ADDR_W-1:0] host_reg_addr;
      logic [HBSD_DATA_W-1:0] host_reg_data;
   } hbsd_pins_s;

   // Decoded access towards the register file
   typedef struct packed {
      logic rd;
      logic wr;
      logic [HBSD_ADDR_W-1:0] addr;
      logic [HBSD_DATA_W-1:0] wdata;
   } hbsd_req_s;
endpackage

// file: rtl/hbsd_sync.sv
// Two-stage synchroniser for a bundle of host pins
`timescale 1ns/1ns
`default_nettype none
module hbsd_sync #(
   parameter int WIDTH = 1
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg;
endmodule
`default_nettype wire

// file: rtl/hbsd_top.sv
// Strobe, direction and address decode of the parallel host port
// Summary of operation
// - Sync mode: shared pin is address strobe
// - Sync mode: access only while strobe low
// - Async mode: shared pin low writes data
// - Async write needs select low, read high, reset high
// - Eleven-bit address selects the register
// - Sync mode: direction high writes, low reads
// - Async mode: read strobe low reads register
`timescale 1ns/1ns
`default_nettype none
module hbsd_top
   import hbsd_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_port_select_n,
   input wire logic i_bus_protocol_select,
   input wire logic i_addr_strobe_shared_n,
   input wire logic i_dir_shared,
   input wire logic i_dev_reset_n,
   input wire logic i_host_port_clock,
   input wire logic [hbsd_pkg::HBSD_ADDR_W-1:0] i_host_reg_addr,
   input wire logic [hbsd_pkg::HBSD_DATA_W-1:0] i_host_reg_data,
   input wire logic [hbsd_pkg::HBSD_DATA_W-1:0] i_reg_rdata,
   output logic o_reg_rd,
   output logic o_reg_wr,
   output logic [hbsd_pkg::HBSD_ADDR_W-1:0] o_reg_addr,
   output logic [hbsd_pkg::HBSD_DATA_W-1:0] o_reg_wdata,
   output logic [hbsd_pkg::HBSD_DATA_W-1:0] o_host_reg_data,
   output logic o_host_reg_data_oe
);
   import hbsd_pkg::*;

   localparam int PIN_W = $bits(hbsd_pins_s);

   hbsd_pins_s raw;
   hbsd_pins_s pin;
   logic [PIN_W-1:0] pin_vec;

   // One driver for the whole bundle
   assign raw = '{
      port_select_n: i_port_select_n,
      bus_protocol_select: i_bus_protocol_select,
      shared_strobe_n: i_addr_strobe_shared_n,
      shared_dir: i_dir_shared,
      dev_reset_n: i_dev_reset_n,
      host_port_clock: i_host_port_clock,
      host_reg_addr: i_host_reg_addr,
      host_reg_data: i_host_reg_data
   };

   hbsd_sync #(
      .WIDTH(PIN_W)
   ) hbsd_sync_inst (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_async(raw),
      .o_sync(pin_vec)
   );
   assign pin = hbsd_pins_s'(pin_vec);

   // Classify the current pin state into an access kind
   function automatic hbsd_acc_e decode_acc(input hbsd_pins_s p);
      hbsd_acc_e k;
      k = HBSD_ACC_NONE;
      if (p.port_select_n || !p.dev_reset_n) begin
         k = HBSD_ACC_NONE;
      end else if (p.bus_protocol_select == HBSD_MODE_SYNC) begin
         if (!p.shared_strobe_n) begin
            k = p.shared_dir ? HBSD_ACC_WRITE : HBSD_ACC_READ;
         end
      end else begin
         if (!p.shared_dir) begin
            k = HBSD_ACC_READ;
         end else if (!p.shared_strobe_n) begin
            k = HBSD_ACC_WRITE;
         end
      end
      return k;
   endfunction

   hbsd_acc_e acc_now;
   hbsd_acc_e acc_reg;
   hbsd_acc_e acc_next;
   hbsd_req_s req_reg;
   hbsd_req_s req_next;
   logic clk_q_reg;
   logic clk_q_next;
   logic [HBSD_DATA_W-1:0] rdata_reg;
   logic [HBSD_DATA_W-1:0] rdata_next;
   logic oe_reg;
   logic oe_next;
   logic clk_rise;

   assign acc_now = decode_acc(pin);
   assign clk_rise = pin.host_port_clock && !clk_q_reg;

   // Async mode: one write pulse per strobe; sync mode writes on every port clock rise while strobed
   always_comb begin
      acc_next = acc_now;
      clk_q_next = pin.host_port_clock;
      req_next = req_reg;
      req_next.rd = 1'b0;
      req_next.wr = 1'b0;
      rdata_next = rdata_reg;
      oe_next = 1'b0;
      if (acc_now == HBSD_ACC_READ) begin
         req_next.rd = (acc_reg != HBSD_ACC_READ);
         req_next.addr = pin.host_reg_addr;
         rdata_next = i_reg_rdata;
         oe_next = 1'b1;
      end else if (acc_now == HBSD_ACC_WRITE) begin
         if (pin.bus_protocol_select == HBSD_MODE_SYNC) begin
            req_next.wr = clk_rise;
         end else begin
            req_next.wr = (acc_reg != HBSD_ACC_WRITE);
         end
         req_next.addr = pin.host_reg_addr;
         req_next.wdata = pin.host_reg_data;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         acc_reg <= HBSD_ACC_NONE;
         clk_q_reg <= 1'b0;
         req_reg <= '{rd: 1'b0, wr: 1'b0, addr: HBSD_ADDR_RST,
                      wdata: HBSD_DATA_RST};
         rdata_reg <= HBSD_DATA_RST;
         oe_reg <= 1'b0;
      end else begin
         acc_reg <= acc_next;
         clk_q_reg <= clk_q_next;
         req_reg <= req_next;
         rdata_reg <= rdata_next;
         oe_reg <= oe_next;
      end
   end

   assign o_reg_rd = req_reg.rd;
   assign o_reg_wr = req_reg.wr;
   assign o_reg_addr = req_reg.addr;
   assign o_reg_wdata = req_reg.wdata;
   assign o_host_reg_data = rdata_reg;
   assign o_host_reg_data_oe = oe_reg;

   property p_sync_no_strobe_no_write;
      @(posedge i_clk) disable iff (i_sys_rst)
      (pin.bus_protocol_select && pin.shared_strobe_n) |=> !o_reg_wr;
   endproperty
   a_sync_no_strobe_no_write: assert property (p_sync_no_strobe_no_write)
      else $error("write without address strobe");

   property p_deselect_float;
      @(posedge i_clk) disable iff (i_sys_rst)
      pin.port_select_n |=> !o_host_reg_data_oe && !o_reg_wr && !o_reg_rd;
   endproperty
   a_deselect_float: assert property (p_deselect_float)
      else $error("deselected port active");

   property p_async_write_cond;
      @(posedge i_clk) disable iff (i_sys_rst)
      o_reg_wr && !$past(pin.bus_protocol_select) |->
         !$past(pin.port_select_n) && $past(pin.shared_dir)
         && $past(pin.dev_reset_n) && !$past(pin.shared_strobe_n);
   endproperty
   a_async_write_cond: assert property (p_async_write_cond)
      else $error("async write without its conditions");

   sequence s_async_rd_req;
      !pin.port_select_n && pin.dev_reset_n && !pin.bus_protocol_select
         && !pin.shared_dir;
   endsequence
   property p_async_read_drive;
      @(posedge i_clk) disable iff (i_sys_rst)
      s_async_rd_req |=> o_host_reg_data_oe;
   endproperty
   a_async_read_drive: assert property (p_async_read_drive)
      else $error("async read not driven");

   property p_sync_dir_write;
      @(posedge i_clk) disable iff (i_sys_rst)
      o_reg_wr |-> !o_host_reg_data_oe && $past(pin.shared_dir);
   endproperty
   a_sync_dir_write: assert property (p_sync_dir_write)
      else $error("write while driving data");

   // Device reset pin low blocks every access
   property p_reset_pin_blocks;
      @(posedge i_clk) disable iff (i_sys_rst)
      !pin.dev_reset_n |=> !o_reg_wr && !o_reg_rd && !o_host_reg_data_oe;
   endproperty
   a_reset_pin_blocks: assert property (p_reset_pin_blocks)
      else $error("access while device reset low");

   property p_sync_read_dir;
      @(posedge i_clk) disable iff (i_sys_rst)
      o_reg_rd && $past(pin.bus_protocol_select) |->
         !$past(pin.shared_dir) && !$past(pin.shared_strobe_n);
   endproperty
   a_sync_read_dir: assert property (p_sync_read_dir)
      else $error("sync read without strobe or with direction high");

   property p_write_single;
      @(posedge i_clk) disable iff (i_sys_rst)
      o_reg_wr |=> !o_reg_wr;
   endproperty
   a_write_single: assert property (p_write_single)
      else $error("write pulse too long");

   property p_addr_capture;
      @(posedge i_clk) disable iff (i_sys_rst)
      o_reg_wr |-> o_reg_addr == $past(pin.host_reg_addr);
   endproperty
   a_addr_capture: assert property (p_addr_capture)
      else $error("address not captured");

   property p_sync_write_on_strobe;
      @(posedge i_clk) disable iff (i_sys_rst)
      o_reg_wr && $past(pin.bus_protocol_select) |->
         !$past(pin.shared_strobe_n) && $past(pin.shared_dir);
   endproperty
   a_sync_write_on_strobe: assert property (p_sync_write_on_strobe)
      else $error("sync write without strobe");
endmodule
`default_nettype wire

// file: tb/hbsd_host_model.sv
// Host processor model driving the parallel port pins
`timescale 1ns/1ns
`default_nettype none
module hbsd_host_model (
   input wire logic i_clk,
   output logic o_sel_n,
   output logic o_mode,
   output logic o_stb_n,
   output logic o_dir,
   output logic o_rst_n,
   output logic o_pclk,
   output logic [hbsd_pkg::HBSD_ADDR_W-1:0] o_addr,
   output logic [hbsd_pkg::HBSD_DATA_W-1:0] o_data
);
   import hbsd_pkg::*;
   initial begin
      {o_sel_n, o_mode, o_stb_n, o_dir, o_rst_n, o_pclk} = 6'b10_1110;
      o_addr = HBSD_ADDR_RST;
      o_data = 8'h5A;
   end
   // Select, mode, strobe, direction and reset all move together
   task automatic pins(input logic s, m, t, d, r,
         input logic [HBSD_ADDR_W-1:0] a, input logic [HBSD_DATA_W-1:0] w);
      @(posedge i_clk);
      #1;
      {o_sel_n, o_mode, o_stb_n, o_dir, o_rst_n} = {s, m, t, d, r};
      o_addr = a;
      o_data = w;
   endtask
   // Released data lines do not keep the last value
   task automatic idle;
      pins(1'b1, o_mode, 1'b1, 1'b1, 1'b1, o_addr, ~o_data);
   endtask
   task automatic port_clk(input logic v);
      @(posedge i_clk);
      #1;
      o_pclk = v;
   endtask
endmodule
`default_nettype wire

// file: tb/host_bus_strobe_decode_test.sv
// Self-checking bench for the host bus strobe decode block
`timescale 1ns/1ns
`default_nettype none
module host_bus_strobe_decode_test;
   import hbsd_pkg::*;
   logic clk, rst, rd, wr, oe, h;
   logic sel_n, mode, stb_n, dir, rst_n, pclk;
   logic [HBSD_ADDR_W-1:0] addr, raddr;
   logic [HBSD_DATA_W-1:0] data, wdata, hdata, rdata;
   int n_fail = 0;
   int n_checks = 0;
   // Register file stand-in: data is a fixed function of the address
   assign rdata = raddr[7:0] ^ 8'hC3;
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   hbsd_top hbsd_top_inst (.i_clk(clk), .i_sys_rst(rst),
      .i_port_select_n(sel_n), .i_bus_protocol_select(mode),
      .i_addr_strobe_shared_n(stb_n), .i_dir_shared(dir),
      .i_dev_reset_n(rst_n), .i_host_port_clock(pclk),
      .i_host_reg_addr(addr), .i_host_reg_data(data), .i_reg_rdata(rdata),
      .o_reg_rd(rd), .o_reg_wr(wr), .o_reg_addr(raddr), .o_reg_wdata(wdata),
      .o_host_reg_data(hdata), .o_host_reg_data_oe(oe));
   hbsd_host_model hbsd_host_model_inst (.i_clk(clk), .o_sel_n(sel_n),
      .o_mode(mode), .o_stb_n(stb_n), .o_dir(dir), .o_rst_n(rst_n),
      .o_pclk(pclk), .o_addr(addr), .o_data(data));
   task automatic chk(input string nm, input logic [10:0] e, g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Bounded watch for a read or write pulse
   task automatic see(input logic is_rd, output logic hit);
      hit = 1'b0;
      for (int i = 0; i < 8 && hit === 1'b0; i++) begin
         @(posedge clk);
         #2;
         hit = is_rd ? rd : wr;
      end
   endtask
   task automatic rest;
      hbsd_host_model_inst.idle;
      repeat (5) @(posedge clk);
   endtask
   task automatic t_async_wr;
      hbsd_host_model_inst.pins(0, 0, 0, 1, 1, 11'h7FF, 8'hA5);
      see(0, h);
      chk("wr", 1, h);
      chk("addr", 11'h7FF, raddr);
      chk("wdata", 8'hA5, wdata);
      see(0, h);
      chk("wr once", 0, h);
      rest;
   endtask
   task automatic t_async_block;
      for (int k = 0; k < 3; k++) begin
         hbsd_host_model_inst.pins(k == 0, 0, 0, k != 1, k != 2, 11'h155, 8'h3C);
         see(0, h);
         chk("blocked wr", 0, h);
         rest;
      end
   endtask
   task automatic t_read(input logic m, input logic [10:0] a);
      hbsd_host_model_inst.pins(0, m, !m, 0, 1, a, 8'h00);
      see(1, h);
      chk("rd", 1, h);
      repeat (2) @(posedge clk);
      #2;
      chk("oe", 1, oe);
      chk("rdata", a[7:0] ^ 8'hC3, hdata);
      chk("raddr", a, raddr);
      rest;
      #2;
      chk("oe off", 0, oe);
   endtask
   task automatic t_sync_wr(input logic s, t, input logic exp);
      hbsd_host_model_inst.pins(s, 1, t, 1, 1, 11'h400, 8'h96);
      repeat (4) @(posedge clk);
      hbsd_host_model_inst.port_clk(1);
      see(0, h);
      chk("sync wr", exp, h);
      if (exp) begin
         chk("sync addr", 11'h400, raddr);
         chk("sync wdata", 8'h96, wdata);
      end
      hbsd_host_model_inst.port_clk(0);
      rest;
   endtask
   initial begin
      rst = 1'b1;
      repeat (20) @(posedge clk);
      #1;
      rst = 1'b0;
      repeat (4) @(posedge clk);
      #2;
      chk("oe reset", 0, oe);
      chk("wr reset", 0, wr);
      t_async_wr;
      t_async_block;
      t_read(0, 11'h2B6);
      t_sync_wr(0, 1, 0);
      t_sync_wr(1, 0, 0);
      t_sync_wr(0, 0, 1);
      t_read(1, 11'h0F0);
      finish_test;
   end
endmodule
`default_nettype wire
